// File: logic/owl_osc_ctrl_lock.sv
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module owl_osc_ctrl_lock
   import owl_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic primary_osc_fail,
   input wire logic wdt_osc_fail,
   output owl_ctrl_t osc_ctrl,
   output logic irq
);

   // ***************************************************************
   // Failure input synchronisers
   // ***************************************************************
   logic [1:0] fail_meta_ff;
   logic [1:0] fail_sync_ff;

   // Fail lines come from the analog detectors, outside our clock
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fail_meta_ff <= 2'h0;
         fail_sync_ff <= 2'h0;
      end else begin
         fail_meta_ff <= {wdt_osc_fail, primary_osc_fail};
         fail_sync_ff <= fail_meta_ff;
      end
   end

   // ***************************************************************
   // APB decode
   // ***************************************************************
   logic pready_ff, nxt_pready;
   logic pslverr_ff, nxt_pslverr;
   logic [31:0] prdata_ff, nxt_prdata;
   logic acc, wr_done, mapped;
   logic wr_ctrl, wr_stat, wr_mask;

   owl_lock_t lock_ff, nxt_lock;
   owl_ctrl_t ctrl_ff, nxt_ctrl;
   logic [OWL_EV_W-1:0] stat_ff, nxt_stat;
   logic [OWL_EV_W-1:0] mask_ff, nxt_mask;
   logic irq_ff, nxt_irq;
   logic [OWL_EV_W-1:0] ev;
   logic recover;

   // One wait state: pready rises in the second access cycle
   assign acc = psel && penable && !pready_ff;
   assign wr_done = psel && penable && pready_ff && pwrite;
   assign mapped = (paddr == OWL_OFF_CTRL) || (paddr == OWL_OFF_STAT) ||
                   (paddr == OWL_OFF_MASK) || (paddr == OWL_OFF_LOCK);
   assign wr_ctrl = wr_done && (paddr == OWL_OFF_CTRL);
   assign wr_stat = wr_done && (paddr == OWL_OFF_STAT);
   assign wr_mask = wr_done && (paddr == OWL_OFF_MASK);

   // Read data and answer, both prepared one cycle before pready
   always_comb begin
      nxt_pready = acc;
      nxt_pslverr = acc && !mapped;
      nxt_prdata = 32'h0000_0000;
      if (acc && !pwrite) begin
         unique case (paddr)
            OWL_OFF_CTRL: nxt_prdata = {24'h00_0000, ctrl_ff};
            OWL_OFF_STAT: nxt_prdata = {28'h000_0000, stat_ff};
            OWL_OFF_MASK: nxt_prdata = {28'h000_0000, mask_ff};
            OWL_OFF_LOCK: nxt_prdata = {30'h0000_0000, lock_ff};
            default: nxt_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         prdata_ff <= nxt_prdata;
      end
   end

   // ***************************************************************
   // Lock sequencer and control register
   // ***************************************************************
   // Recovery only if watchdog oscillator runs and is not already the source
   assign recover = fail_sync_ff[0] && ctrl_ff.primary_osc_fail_detect_en &&
                    ctrl_ff.wdt_osc_en && (ctrl_ff.clock_source_select != OWL_SRC_WDT);

   // Only writes to the control offset move the sequencer
   always_comb begin
      nxt_lock = lock_ff;
      nxt_ctrl = ctrl_ff;
      ev = OWL_EV_RST;
      if (wr_ctrl) begin
         unique case (lock_ff)
            OWL_LOCKED: begin
               if (pwdata[7:0] == OWL_KEY_FIRST) begin
                  nxt_lock = OWL_KEY1;
               end else begin
                  ev[OWL_EV_IGNORED] = 1'b1;
               end
            end
            OWL_KEY1: begin
               if (pwdata[7:0] == OWL_KEY_SECOND) begin
                  nxt_lock = OWL_UNLOCKED;
               end else if (pwdata[7:0] != OWL_KEY_FIRST) begin
                  nxt_lock = OWL_LOCKED;
                  ev[OWL_EV_IGNORED] = 1'b1;
               end
            end
            OWL_UNLOCKED: begin
               // Only a written value touches the oscillator enable
               nxt_ctrl = owl_ctrl_t'(pwdata[7:0]);
               nxt_lock = OWL_LOCKED;
               ev[OWL_EV_UPDATED] = 1'b1;
               // Detector left on across a switch sees a false failure
               if (nxt_ctrl.clock_source_select != ctrl_ff.clock_source_select) begin
                  ev[OWL_EV_PFAIL] = ctrl_ff.primary_osc_fail_detect_en;
                  ev[OWL_EV_WFAIL] = ctrl_ff.wdt_osc_fail_detect_en;
               end
            end
            default: nxt_lock = OWL_LOCKED;
         endcase
      end
      // Real failures from the detectors
      if (fail_sync_ff[0] && ctrl_ff.primary_osc_fail_detect_en) begin
         ev[OWL_EV_PFAIL] = 1'b1;
      end
      if (fail_sync_ff[1] && ctrl_ff.wdt_osc_fail_detect_en) begin
         ev[OWL_EV_WFAIL] = 1'b1;
      end
      // Hardware switch-over beats a software update in the same cycle
      if (recover) begin
         nxt_ctrl.clock_source_select = OWL_SRC_WDT;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lock_ff <= OWL_LOCKED;
         ctrl_ff <= OWL_CTRL_RST;
      end else begin
         lock_ff <= nxt_lock;
         ctrl_ff <= nxt_ctrl;
      end
   end

   // ***************************************************************
   // Interrupt status, mask and output
   // ***************************************************************
   // New events win over a write-one-to-clear in the same cycle
   always_comb begin
      nxt_stat = stat_ff;
      nxt_mask = mask_ff;
      if (wr_stat) begin
         nxt_stat = stat_ff & ~pwdata[OWL_EV_W-1:0];
      end
      nxt_stat = nxt_stat | ev;
      if (wr_mask) begin
         nxt_mask = pwdata[OWL_EV_W-1:0];
      end
      nxt_irq = |(nxt_stat & nxt_mask);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stat_ff <= OWL_EV_RST;
         mask_ff <= OWL_EV_RST;
         irq_ff <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
         irq_ff <= nxt_irq;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign osc_ctrl = ctrl_ff;
   assign irq = irq_ff;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   // A write of one given key value to the control offset
   sequence s_key_write(logic [7:0] key);
      wr_ctrl && (pwdata[7:0] == key);
   endsequence

   property p_unlock_order;
      @(posedge clk) disable iff (!resetn)
      (lock_ff != OWL_UNLOCKED) ##1 (lock_ff == OWL_UNLOCKED) |->
         $past(lock_ff) == OWL_KEY1 && $past(pwdata[7:0]) == OWL_KEY_SECOND;
   endproperty
   a_unlock_order: assert property (p_unlock_order)
      else $error("unlock reached without ordered keys");

   property p_update_relock;
      @(posedge clk) disable iff (!resetn)
      (lock_ff == OWL_UNLOCKED) and wr_ctrl and !recover |=>
         (lock_ff == OWL_LOCKED) && (ctrl_ff == $past(pwdata[7:0]));
   endproperty
   a_update_relock: assert property (p_update_relock)
      else $error("unlocked write did not load and relock");

   property p_ignore_locked;
      @(posedge clk) disable iff (!resetn)
      (lock_ff != OWL_UNLOCKED) and !recover |=> $stable(ctrl_ff);
   endproperty
   a_ignore_locked: assert property (p_ignore_locked)
      else $error("control changed while locked");

   property p_key_gap;
      @(posedge clk) disable iff (!resetn)
      (lock_ff != OWL_UNLOCKED) ##0 s_key_write(OWL_KEY_FIRST) ##1 (!wr_ctrl)[*4]
         ##1 s_key_write(OWL_KEY_SECOND)
         |-> (lock_ff == OWL_KEY1) ##1 (lock_ff == OWL_UNLOCKED);
   endproperty
   a_key_gap: assert property (p_key_gap)
      else $error("separated keys not accepted");

   property p_other_access;
      @(posedge clk) disable iff (!resetn)
      !wr_ctrl |=> $stable(lock_ff);
   endproperty
   a_other_access: assert property (p_other_access)
      else $error("sequencer moved without control write");

   property p_switch_flag;
      @(posedge clk) disable iff (!resetn)
      (lock_ff == OWL_UNLOCKED) && wr_ctrl && ctrl_ff.primary_osc_fail_detect_en &&
         (pwdata[2:0] != ctrl_ff.clock_source_select) |=> stat_ff[OWL_EV_PFAIL] ##1 irq
         || !mask_ff[OWL_EV_PFAIL];
   endproperty
   a_switch_flag: assert property (p_switch_flag)
      else $error("switch with detector on raised no flag");

   property p_reset_ipo;
      @(posedge clk) disable iff (!resetn)
      !$past(resetn) |-> ctrl_ff.internal_precision_osc && (lock_ff == OWL_LOCKED);
   endproperty
   a_reset_ipo: assert property (p_reset_ipo)
      else $error("reset state wrong");

   property p_ipo_kept;
      @(posedge clk) disable iff (!resetn)
      $fell(ctrl_ff.internal_precision_osc) |->
         $past(wr_ctrl) && ($past(lock_ff) == OWL_UNLOCKED) && !$past(pwdata[7]);
   endproperty
   a_ipo_kept: assert property (p_ipo_kept)
      else $error("precision oscillator dropped without a write");

   property p_recover;
      @(posedge clk) disable iff (!resetn)
      recover |=> (ctrl_ff.clock_source_select == OWL_SRC_WDT) && stat_ff[OWL_EV_PFAIL];
   endproperty
   a_recover: assert property (p_recover)
      else $error("no switch-over to watchdog oscillator");

   // A bad first key is flagged and leaves the sequencer locked
   property p_bad_key;
      @(posedge clk) disable iff (!resetn)
      (lock_ff == OWL_LOCKED) && wr_ctrl && (pwdata[7:0] != OWL_KEY_FIRST) |=>
         stat_ff[OWL_EV_IGNORED] && (lock_ff == OWL_LOCKED);
   endproperty
   a_bad_key: assert property (p_bad_key)
      else $error("bad key not flagged or sequencer moved");

   // Watchdog detector failure lands in status one edge later
   property p_wfail_flag;
      @(posedge clk) disable iff (!resetn)
      fail_sync_ff[1] && ctrl_ff.wdt_osc_fail_detect_en |=> stat_ff[OWL_EV_WFAIL];
   endproperty
   a_wfail_flag: assert property (p_wfail_flag)
      else $error("watchdog oscillator failure not flagged");

endmodule : owl_osc_ctrl_lock

`default_nettype wire

// File: logic/owl_pkg.sv
// ***************************************************************
// Oscillator control write-lock package
// ***************************************************************
package owl_pkg;

   // Register byte offsets
   localparam logic [11:0] OWL_OFF_CTRL = 12'h000;
   localparam logic [11:0] OWL_OFF_STAT = 12'h004;
   localparam logic [11:0] OWL_OFF_MASK = 12'h008;
   localparam logic [11:0] OWL_OFF_LOCK = 12'h00C;

   // Unlock key values, in the order they must arrive
   localparam logic [7:0] OWL_KEY_FIRST = 8'hE7;
   localparam logic [7:0] OWL_KEY_SECOND = 8'h18;

   // Clock source select codes
   localparam logic [2:0] OWL_SRC_IPO = 3'h0;
   localparam logic [2:0] OWL_SRC_XTAL = 3'h1;
   localparam logic [2:0] OWL_SRC_EXT = 3'h2;
   localparam logic [2:0] OWL_SRC_WDT = 3'h3;

   // Status / mask bit positions
   localparam int OWL_EV_PFAIL = 0;
   localparam int OWL_EV_WFAIL = 1;
   localparam int OWL_EV_IGNORED = 2;
   localparam int OWL_EV_UPDATED = 3;
   localparam int OWL_EV_W = 4;

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic internal_precision_osc;
      logic xtal_en;
      logic wdt_osc_en;
      logic primary_osc_fail_detect_en;
      logic wdt_osc_fail_detect_en;
      logic [2:0] clock_source_select;
   } owl_ctrl_t;

   // Internal precision oscillator and watchdog oscillator run after reset
   localparam owl_ctrl_t OWL_CTRL_RST = 8'hA0;
   localparam logic [OWL_EV_W-1:0] OWL_EV_RST = 4'h0;

   typedef enum logic [1:0] {
      OWL_LOCKED,
      OWL_KEY1,
      OWL_UNLOCKED
   } owl_lock_t;

endpackage : owl_pkg

// File: bench/owl_apb_cpu.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************
// CPU-side register bus master model
// ************************************
module owl_apb_cpu (
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end

   // One transfer; waits on pready as long as it takes, the bench watchdog ends a dead wait
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines show junk, never the old value
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : owl_apb_cpu
`default_nettype wire

// File: bench/tb_osc_ctrl_write_lock.sv
`timescale 1ns/1ps
`default_nettype none
module tb_osc_ctrl_write_lock
   import owl_pkg::*;
;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic primary_osc_fail = 1'b0;
   logic wdt_osc_fail = 1'b0;
   owl_ctrl_t osc_ctrl;
   int errors = 0;
   int compares = 0;
   int m_ctrl, m_lock, m_stat, m_mask, n;
   logic [31:0] seed = 32'h0479;

   owl_osc_ctrl_lock i_owl_osc_ctrl_lock (.clk(clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .primary_osc_fail(primary_osc_fail),
      .wdt_osc_fail(wdt_osc_fail), .osc_ctrl(osc_ctrl), .irq(irq));
   owl_apb_cpu i_owl_apb_cpu (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // 200 MHz clock
   initial begin
      forever #2.5 clk = ~clk;
   end

   // ************************************
   // Checking and model helpers
   // ************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // Write, track expected state, then compare control and irq once settled
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      i_owl_apb_cpu.xfer(a, 1'b1, {24'h0, d}, r, e);
      if (a == OWL_OFF_CTRL) begin
         if (m_lock == 2) begin
            // Detectors still on from the old value flag the switch
            if (d[2:0] != m_ctrl[2:0]) m_stat = m_stat | m_ctrl[4] | (m_ctrl[3] << 1);
            m_ctrl = d;
            m_stat |= 8;
            m_lock = 0;
         end else if (d == OWL_KEY_FIRST) m_lock = 1;
         else if (m_lock == 1 && d == OWL_KEY_SECOND) m_lock = 2;
         else begin
            m_stat |= 4;
            m_lock = 0;
         end
      end else if (a == OWL_OFF_STAT) m_stat &= ~d[3:0];
      else if (a == OWL_OFF_MASK) m_mask = d[3:0];
      @(posedge clk);
      @(negedge clk);
      chk({24'h0, osc_ctrl}, m_ctrl);
      chk({31'h0, irq}, (m_stat & m_mask) != 0);
   endtask : wr

   task automatic rd(input logic [11:0] a);
      logic [31:0] r;
      logic e;
      int x;
      i_owl_apb_cpu.xfer(a, 1'b0, seed, r, e);
      case (a)
         OWL_OFF_CTRL: x = m_ctrl;
         OWL_OFF_STAT: x = m_stat;
         OWL_OFF_MASK: x = m_mask;
         OWL_OFF_LOCK: x = m_lock;
         default: x = 0;
      endcase
      chk(r, x);
      chk({31'h0, e}, a > OWL_OFF_LOCK);
   endtask : rd

   task automatic unlock();
      wr(OWL_OFF_CTRL, OWL_KEY_FIRST);
      wr(OWL_OFF_CTRL, OWL_KEY_SECOND);
   endtask : unlock

   // Reset held 12 cycles; model follows the documented reset state
   task automatic do_reset();
      @(posedge clk);
      resetn <= 1'b0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      m_ctrl = OWL_CTRL_RST;
      m_lock = 0;
      m_stat = 0;
      m_mask = 0;
   endtask : do_reset

   task automatic test_done();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done

   // Watchdog, generous against roughly three hundred cycles of traffic
   initial begin
      repeat (8000) @(posedge clk);
      errors++;
      test_done();
   end

   // ************************************
   // Scenarios
   // ************************************
   initial begin
      do_reset();
      for (int a = 0; a <= 16; a += 4) rd(a[11:0]);
      // Bad keys flag while masked, then unmask, then W1C
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         wr(OWL_OFF_CTRL, (seed[7:0] == OWL_KEY_FIRST) ? 8'h00 : seed[7:0]);
      end
      wr(OWL_OFF_MASK, 8'h0F);
      wr(OWL_OFF_STAT, 8'h04);
      // Keys split by other accesses, then load and relock
      wr(OWL_OFF_CTRL, OWL_KEY_FIRST);
      rd(OWL_OFF_MASK);
      wr(OWL_OFF_MASK, 8'h0F);
      rd(OWL_OFF_LOCK);
      wr(OWL_OFF_CTRL, OWL_KEY_SECOND);
      rd(OWL_OFF_CTRL);
      rd(OWL_OFF_LOCK);
      wr(OWL_OFF_CTRL, 8'hE1);
      wr(OWL_OFF_CTRL, 8'hA0);
      rd(OWL_OFF_STAT);
      // Wrong order and a broken second step
      wr(OWL_OFF_CTRL, OWL_KEY_SECOND);
      wr(OWL_OFF_CTRL, OWL_KEY_FIRST);
      wr(OWL_OFF_CTRL, 8'h55);
      wr(OWL_OFF_CTRL, OWL_KEY_SECOND);
      // Every select code, random upper bits, detectors off while switching
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         unlock();
         wr(OWL_OFF_CTRL, {seed[7:5], 2'b00, k[2:0]});
      end
      wr(OWL_OFF_STAT, 8'h0F);
      unlock();
      wr(OWL_OFF_CTRL, 8'hE1);
      unlock();
      wr(OWL_OFF_CTRL, 8'hF9);
      unlock();
      wr(OWL_OFF_CTRL, 8'hFA);
      rd(OWL_OFF_STAT);
      wr(OWL_OFF_STAT, 8'h0F);
      // Primary failure forces the watchdog oscillator
      @(posedge clk);
      primary_osc_fail <= 1'b1;
      n = 0;
      while (osc_ctrl.clock_source_select !== OWL_SRC_WDT && n < 20) begin
         @(posedge clk);
         n++;
      end
      primary_osc_fail <= 1'b0;
      m_ctrl = 'hFB;
      repeat (6) @(posedge clk);
      m_stat = 1;
      rd(OWL_OFF_STAT);
      wr(OWL_OFF_STAT, 8'h0F);
      rd(OWL_OFF_STAT);
      @(posedge clk);
      wdt_osc_fail <= 1'b1;
      repeat (4) @(posedge clk);
      wdt_osc_fail <= 1'b0;
      repeat (6) @(posedge clk);
      m_stat = 2;
      rd(OWL_OFF_STAT);
      // Reset in mid-key drops the recorded step
      wr(OWL_OFF_CTRL, OWL_KEY_FIRST);
      do_reset();
      wr(OWL_OFF_CTRL, OWL_KEY_SECOND);
      wr(OWL_OFF_CTRL, 8'h55);
      rd(OWL_OFF_LOCK);
      test_done();
   end
endmodule : tb_osc_ctrl_write_lock
`default_nettype wire
